// ---- ptb_pkg.sv ----
// Constants shared by the PHY 10BASE-T, self-test and cable diagnostic register block.
// Assumes a single 10 MHz management clock and an AXI4-Lite register master.
package ptb_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_GEN_STATUS = 6'h10;
	localparam logic [5:0] IDX_TEN_SC = 6'h1a;
	localparam logic [5:0] IDX_ST_ONE = 6'h1b;
	localparam logic [5:0] IDX_ST_LEN = 6'h1c;
	localparam logic [5:0] IDX_CABLE = 6'h1e;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
	localparam logic [5:0] IDX_ST_MODE = 6'h22;

	// Field positions
	localparam int TSC_LOWTH = 13;
	localparam int TSC_SQ_LO = 9;
	localparam int TSC_NLP = 7;
	localparam int TSC_POL = 4;
	localparam int TSC_JAB = 0;
	localparam int GS_POL = 12;
	localparam int ST_LATCH = 15;
	localparam int ST_CNT_LO = 8;
	localparam int CD_START = 15;
	localparam int CD_RESCAL = 14;
	localparam int CD_DONE = 1;
	localparam int CD_FAIL = 0;
	localparam int MODE_CNT = 0;
	localparam int MODE_GEN = 1;

	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_POL = 2;
	localparam int IRQ_SAT = 3;
	localparam int IRQ_W = 4;

	// Reset values
	localparam logic [7:0] IPG_RST = 8'h7d;
	localparam logic [10:0] LEN_RST = 11'h5ee;
	localparam logic [3:0] SQ_RST = 4'h0;
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

	// Squelch threshold map in millivolts
	localparam logic [9:0] SQ_BASE_MV = 10'h0c8;
	localparam logic [9:0] SQ_STEP_MV = 10'h032;
	localparam logic [3:0] SQ_MAX_CODE = 4'h8;

	localparam logic [7:0] ERR_FULL = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Self-test generator states
	typedef enum logic [1:0] {PTB_IDLE, PTB_PKT, PTB_GAP} ptb_gen_t;

endpackage

// ---- ptb_pkt_gen.sv ----
// Self-test packet timing generator: one byte per clock, fixed length, gap of four bytes per unit.
// Assumes length and gap come from the register block on the same clock.
`timescale 1ns/1ps
module ptb_pkt_gen
	import ptb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [10:0] pkt_len,
	input wire logic [7:0] ipg_len,
	output logic byte_valid,
	output logic pkt_start
);

	ptb_gen_t state_r;
	logic [10:0] cnt_r;
	logic [10:0] gap_ref_r;
	logic [10:0] gap_n_r;
	logic [10:0] len_ref_r;
	logic [10:0] byte_n_r;
	logic can_start;

	assign can_start = enable && (pkt_len != 11'h000);

	////////////////////////////////////////////////////////////////////////////
	// Packet and gap sequencing; a new packet follows the gap with no idle cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= PTB_IDLE;
			cnt_r <= 11'h000;
			byte_valid <= 1'b0;
			pkt_start <= 1'b0;
		end else begin
			pkt_start <= 1'b0;
			unique case (state_r)
				PTB_IDLE: begin
					if (can_start) begin
						state_r <= PTB_PKT;
						cnt_r <= pkt_len - 11'h001;
						byte_valid <= 1'b1;
						pkt_start <= 1'b1;
					end
				end
				PTB_PKT: begin
					if (cnt_r != 11'h000) begin
						cnt_r <= cnt_r - 11'h001;
					end else if (ipg_len != 8'h00) begin
						state_r <= PTB_GAP;
						cnt_r <= {1'b0, ipg_len, 2'b00} - 11'h001;
						byte_valid <= 1'b0;
					end else if (can_start) begin
						cnt_r <= pkt_len - 11'h001;
						pkt_start <= 1'b1;
					end else begin
						state_r <= PTB_IDLE;
						byte_valid <= 1'b0;
					end
				end
				PTB_GAP: begin
					if (cnt_r != 11'h000) begin
						cnt_r <= cnt_r - 11'h001;
					end else if (can_start) begin
						state_r <= PTB_PKT;
						cnt_r <= pkt_len - 11'h001;
						byte_valid <= 1'b1;
						pkt_start <= 1'b1;
					end else begin
						state_r <= PTB_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helper counts for the checks below
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			len_ref_r <= 11'h000;
			byte_n_r <= 11'h000;
			gap_ref_r <= 11'h000;
			gap_n_r <= 11'h000;
		end else begin
			if (pkt_start) begin
				len_ref_r <= pkt_len;
			end
			byte_n_r <= pkt_start ? 11'h001 : (byte_valid ? byte_n_r + 11'h001 : 11'h000);
			if (state_r == PTB_PKT && cnt_r == 11'h000) begin
				gap_ref_r <= {1'b0, ipg_len, 2'b00};
			end
			gap_n_r <= (state_r == PTB_GAP) ? gap_n_r + 11'h001 : 11'h000;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// The byte count trails the byte by one cycle, so the last byte sees one less than the length
	pkt_length_a: assert property (byte_valid && !pkt_start && state_r == PTB_PKT && cnt_r == 11'h000
		|-> byte_n_r + 11'h001 == len_ref_r) else $error("packet length differs from field");
	gap_length_a: assert property (state_r == PTB_GAP && cnt_r == 11'h000
		|-> gap_n_r + 11'h001 == gap_ref_r) else $error("gap is not four bytes per unit");
	gen_gap_c: cover property (state_r == PTB_GAP ##1 state_r == PTB_PKT);

endmodule

// ---- ptb_regs.sv ----
// Register block for 10BASE-T receive tuning, self-test error counting and cable diagnostics.
// Assumes an AXI4-Lite master on ref_clk, and measurement and checker pulses on the same clock.
// Behaviour
// - Lower-threshold bit selects reduced 10BASE-T receive threshold; clear means normal.
// - Squelch code 0 gives 200 mV, plus 50 mV per code, code 8 is 600 mV.
// - Link pulses are sent while the disable bit is zero, suppressed while one.
// - Read-only polarity bit shows inverted polarity, mirroring general status polarity bit.
// - Reading the 10BASE-T register clears both polarity copies; general status read keeps them.
// - Jabber disable bit turns jabber off, only during 10BASE-Te operation.
// - Eight-bit error count accumulates errored bytes seen by the sequence checker.
// - Writing one to the top bit latches the count for reads and clears the counter.
// - With counter mode zero the error counter saturates at all ones.
// - Generator gap between packets is four times the gap field in bytes, reset 0x7D.
// - Every generated packet is as long as the length field, reset 0x05EE.
// - Software sets diagnostic start; hardware clears it when done is raised.
// - Done bit is set when measurement completes, zero until then.
// - Fail bit is set when measurement fails, zero otherwise.
`timescale 1ns/1ps
module ptb_regs
	import ptb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pol_inverted_pin,
	input wire logic ten_mode_pin,
	input wire logic prbs_err,
	input wire logic diag_done_in,
	input wire logic diag_fail_in,
	output logic lower_thresh_en,
	output logic [3:0] squelch_code,
	output logic [9:0] squelch_mv,
	output logic nlp_tx_en,
	output logic jabber_off,
	output logic diag_start,
	output logic rescal_start,
	output logic bist_byte_valid,
	output logic bist_pkt_start,
	output logic irq
);

	logic aw_held_r, w_held_r;
	logic [7:0] awaddr_r;
	logic [15:0] wdata_r;
	logic [1:0] wstrb_r;
	logic wr_do, rd_do;
	logic [5:0] wr_idx, rd_idx;
	logic wr_ok, rd_ok;
	logic [15:0] rd_val;
	logic lowth_r, nlp_dis_r, jab_r;
	logic [3:0] squelch_r;
	logic [7:0] ipg_r;
	logic [10:0] pkt_len_r;
	logic cd_done_r, cd_fail_r;
	logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
	logic cnt_mode_r, gen_en_r;
	logic [7:0] err_cnt_r, err_lat_r;
	logic pol_r, pol_meta_r, pol_sync_r, ten_meta_r, ten_sync_r;
	logic st_latch, cd_wr, pol_rd_clr;

	////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order, one write at a time
	assign wr_do = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx = awaddr_r[7:2];
	assign wr_ok = (awaddr_r[1:0] == 2'b00) && (wr_idx == IDX_TEN_SC || wr_idx == IDX_ST_ONE ||
		wr_idx == IDX_ST_LEN || wr_idx == IDX_CABLE || wr_idx == IDX_GEN_STATUS ||
		wr_idx == IDX_IRQ_STAT || wr_idx == IDX_IRQ_MASK || wr_idx == IDX_ST_MODE);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			aw_held_r <= 1'b0;
			awaddr_r <= 8'h00;
		end else if (s_axi_awready && s_axi_awvalid) begin
			s_axi_awready <= 1'b0;
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else begin
			if (wr_do) begin
				aw_held_r <= 1'b0;
			end
			s_axi_awready <= !aw_held_r && !s_axi_bvalid;
		end
	end

	// Only the low two byte lanes carry register bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_wready <= 1'b0;
			w_held_r <= 1'b0;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'b00;
		end else if (s_axi_wready && s_axi_wvalid) begin
			s_axi_wready <= 1'b0;
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata[15:0];
			wstrb_r <= s_axi_wstrb[1:0];
		end else begin
			if (wr_do) begin
				w_held_r <= 1'b0;
			end
			s_axi_wready <= !w_held_r && !s_axi_bvalid;
		end
	end

	// Response after both halves; unmapped or misaligned address answers SLVERR
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle from address to data
	assign rd_do = s_axi_arvalid && s_axi_arready;
	assign rd_idx = s_axi_araddr[7:2];
	assign pol_rd_clr = rd_do && rd_ok && rd_idx == IDX_TEN_SC;

	// Reserved bits are left zero in every word
	always_comb begin
		rd_ok = (s_axi_araddr[1:0] == 2'b00);
		rd_val = 16'h0000;
		unique case (rd_idx)
			IDX_GEN_STATUS: rd_val[GS_POL] = pol_r;
			IDX_TEN_SC: begin
				rd_val[TSC_LOWTH] = lowth_r;
				rd_val[TSC_SQ_LO+3:TSC_SQ_LO] = squelch_r;
				rd_val[TSC_NLP] = nlp_dis_r;
				rd_val[TSC_POL] = pol_r;
				rd_val[TSC_JAB] = jab_r;
			end
			IDX_ST_ONE: rd_val = {err_lat_r, ipg_r};
			IDX_ST_LEN: rd_val[10:0] = pkt_len_r;
			IDX_CABLE: begin
				rd_val[CD_START] = diag_start;
				rd_val[CD_RESCAL] = rescal_start;
				rd_val[CD_DONE] = cd_done_r;
				rd_val[CD_FAIL] = cd_fail_r;
			end
			IDX_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat_r;
			IDX_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask_r;
			IDX_ST_MODE: rd_val[1:0] = {gen_en_r, cnt_mode_r};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_do) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_ok ? {16'h0000, rd_val} : 32'h0000_0000;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for polarity and speed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pol_meta_r <= 1'b0;
			pol_sync_r <= 1'b0;
			ten_meta_r <= 1'b0;
			ten_sync_r <= 1'b0;
		end else begin
			pol_meta_r <= pol_inverted_pin;
			pol_sync_r <= pol_meta_r;
			ten_meta_r <= ten_mode_pin;
			ten_sync_r <= ten_meta_r;
		end
	end

	// One flop serves both copies, so they can never disagree; new detection beats the read clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pol_r <= 1'b0;
		end else if (pol_sync_r) begin
			pol_r <= 1'b1;
		end else if (pol_rd_clr) begin
			pol_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 10BASE-T control fields; bits 15:14, 8, 6:5, 3:1 have no storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lowth_r <= 1'b0;
			squelch_r <= SQ_RST;
			nlp_dis_r <= 1'b0;
			jab_r <= 1'b0;
		end else if (wr_do && wr_ok && wr_idx == IDX_TEN_SC) begin
			if (wstrb_r[1]) begin
				lowth_r <= wdata_r[TSC_LOWTH];
				squelch_r <= wdata_r[TSC_SQ_LO+3:TSC_SQ_LO];
			end
			if (wstrb_r[0]) begin
				nlp_dis_r <= wdata_r[TSC_NLP];
				jab_r <= wdata_r[TSC_JAB];
			end
		end
	end

	// Receiver controls; codes above 8 clamp to the top threshold
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lower_thresh_en <= 1'b0;
			squelch_code <= SQ_RST;
			squelch_mv <= SQ_BASE_MV;
			nlp_tx_en <= 1'b1;
			jabber_off <= 1'b0;
		end else begin
			lower_thresh_en <= lowth_r;
			squelch_code <= squelch_r;
			squelch_mv <= SQ_BASE_MV + SQ_STEP_MV * {6'h00, (squelch_r > SQ_MAX_CODE) ? SQ_MAX_CODE : squelch_r};
			nlp_tx_en <= !nlp_dis_r;
			jabber_off <= jab_r && ten_sync_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Self-test fields and mode
	assign st_latch = wr_do && wr_ok && wr_idx == IDX_ST_ONE && wstrb_r[1] && wdata_r[ST_LATCH];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ipg_r <= IPG_RST;
			pkt_len_r <= LEN_RST;
			cnt_mode_r <= 1'b0;
			gen_en_r <= 1'b0;
		end else if (wr_do && wr_ok) begin
			if (wr_idx == IDX_ST_ONE && wstrb_r[0]) begin
				ipg_r <= wdata_r[7:0];
			end
			if (wr_idx == IDX_ST_LEN) begin
				if (wstrb_r[0]) begin
					pkt_len_r[7:0] <= wdata_r[7:0];
				end
				if (wstrb_r[1]) begin
					pkt_len_r[10:8] <= wdata_r[10:8];
				end
			end
			if (wr_idx == IDX_ST_MODE && wstrb_r[0]) begin
				cnt_mode_r <= wdata_r[MODE_CNT];
				gen_en_r <= wdata_r[MODE_GEN];
			end
		end
	end

	// An error in the latch cycle starts the fresh count at one rather than being lost
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_cnt_r <= 8'h00;
			err_lat_r <= 8'h00;
		end else begin
			if (st_latch) begin
				err_lat_r <= err_cnt_r;
				err_cnt_r <= prbs_err ? 8'h01 : 8'h00;
			end else if (prbs_err) begin
				if (err_cnt_r != ERR_FULL || cnt_mode_r) begin
					err_cnt_r <= err_cnt_r + 8'h01;
				end
			end
		end
	end

	ptb_pkt_gen u_gen (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(gen_en_r),
		.pkt_len(pkt_len_r),
		.ipg_len(ipg_r),
		.byte_valid(bist_byte_valid),
		.pkt_start(bist_pkt_start)
	);

	////////////////////////////////////////////////////////////////////////////
	// Cable diagnostic handshake; a software start beats the automatic clear
	assign cd_wr = wr_do && wr_ok && wr_idx == IDX_CABLE && wstrb_r[1];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			diag_start <= 1'b0;
			rescal_start <= 1'b0;
		end else begin
			if (cd_wr) begin
				diag_start <= wdata_r[CD_START];
				rescal_start <= wdata_r[CD_RESCAL];
			end else if (diag_done_in) begin
				diag_start <= 1'b0;
			end
		end
	end

	// Result bits stay until the next measurement is launched
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cd_done_r <= 1'b0;
			cd_fail_r <= 1'b0;
		end else if (diag_done_in) begin
			cd_done_r <= 1'b1;
			cd_fail_r <= diag_fail_in;
		end else if (cd_wr && wdata_r[CD_START]) begin
			cd_done_r <= 1'b0;
			cd_fail_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky events, write one to clear, a new event wins over the clear
	assign irq_evt[IRQ_DONE] = diag_done_in;
	assign irq_evt[IRQ_FAIL] = diag_done_in && diag_fail_in;
	assign irq_evt[IRQ_POL] = pol_sync_r && !pol_r;
	assign irq_evt[IRQ_SAT] = prbs_err && !st_latch && !cnt_mode_r && err_cnt_r == 8'hfe;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_stat_r <= '0;
			irq_mask_r <= MASK_RST;
			irq <= 1'b0;
		end else begin
			if (wr_do && wr_ok && wr_idx == IDX_IRQ_STAT && wstrb_r[0]) begin
				irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_r <= irq_stat_r | irq_evt;
			end
			if (wr_do && wr_ok && wr_idx == IDX_IRQ_MASK && wstrb_r[0]) begin
				irq_mask_r <= wdata_r[IRQ_W-1:0];
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	lowth_out_a: assert property (lowth_r |=> lower_thresh_en) else $error("lower threshold not applied");
	squelch_map_a: assert property (squelch_r <= SQ_MAX_CODE |=>
		squelch_mv == SQ_BASE_MV + SQ_STEP_MV * {6'h00, $past(squelch_r)}) else $error("squelch level wrong");
	nlp_off_a: assert property (nlp_dis_r |=> !nlp_tx_en) else $error("link pulses not suppressed");
	pol_set_a: assert property (pol_sync_r |=> pol_r) else $error("polarity not reported");
	pol_clear_a: assert property (pol_rd_clr && !pol_sync_r |=> !pol_r) else $error("polarity read clear failed");
	pol_keep_a: assert property (rd_do && rd_idx == IDX_GEN_STATUS && pol_r |=> pol_r) else $error("polarity lost");
	jabber_mode_a: assert property (!ten_sync_r |=> !jabber_off) else $error("jabber off outside 10 Mb/s");
	err_count_a: assert property (prbs_err && !st_latch && err_cnt_r != ERR_FULL |=>
		err_cnt_r == $past(err_cnt_r) + 8'h01) else $error("error count missed");
	err_latch_a: assert property (st_latch |=> err_lat_r == $past(err_cnt_r) && err_cnt_r <= 8'h01)
		else $error("latch and clear failed");
	err_sat_a: assert property (!cnt_mode_r && err_cnt_r == ERR_FULL && !st_latch |=> err_cnt_r == ERR_FULL)
		else $error("error count wrapped");
	start_clr_a: assert property (diag_done_in && !cd_wr |=> !diag_start) else $error("start not cleared");
	diag_done_a: assert property (diag_done_in |=> cd_done_r ##1 $stable(cd_done_r) || $past(cd_wr))
		else $error("done not held");
	diag_fail_a: assert property (!cd_fail_r && !diag_fail_in |=> !cd_fail_r) else $error("spurious fail");
	rsvd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("reserved bits set");

	diag_cycle_c: cover property (cd_wr && wdata_r[CD_START] ##[1:50] diag_done_in);
	err_latch_c: cover property (prbs_err ##[1:20] st_latch);
	pol_read_c: cover property (pol_r ##1 pol_rd_clr);
	irq_raise_c: cover property (!irq ##1 irq);

endmodule

// ---- tb.sv ----
// Self-checking bench for the 10BASE-T, self-test and cable diagnostic register block.
// Assumes ptb_regs on one 10 MHz clock, driven over AXI4-Lite by the tasks below.
`timescale 1ns/1ps
module tb;
	import ptb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic pol_inverted_pin = 1'b0, ten_mode_pin = 1'b0, prbs_err = 1'b0, diag_done_in = 1'b0, diag_fail_in = 1'b0;
	logic lower_thresh_en, nlp_tx_en, jabber_off, diag_start, rescal_start, bist_byte_valid, bist_pkt_start, irq;
	logic [3:0] squelch_code;
	logic [9:0] squelch_mv;
	int fail_count = 0;
	int checks = 0;
	int seed = 57245;

	ptb_regs DUT (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pol_inverted_pin(pol_inverted_pin), .ten_mode_pin(ten_mode_pin), .prbs_err(prbs_err),
		.diag_done_in(diag_done_in), .diag_fail_in(diag_fail_in), .lower_thresh_en(lower_thresh_en),
		.squelch_code(squelch_code), .squelch_mv(squelch_mv), .nlp_tx_en(nlp_tx_en), .jabber_off(jabber_off),
		.diag_start(diag_start), .rescal_start(rescal_start), .bist_byte_valid(bist_byte_valid),
		.bist_pkt_start(bist_pkt_start), .irq(irq));

	// 100 ns period
	always #50 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	// A missing handshake ends the run rather than hanging it
	task automatic tmo(input string name);
		chk(name, 32'h1, 32'h0);
		wrap_up();
	endtask

	function automatic logic [9:0] sq_mv(input logic [3:0] c);
		return (c > 4'h8) ? 10'h258 : 10'h0c8 + 10'h032 * {6'h0, c};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master; each channel drops valid on the edge it is taken
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 50) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = 100;
			end
		end
		if (n < 100) tmo("bvalid");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 50) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = 100;
			end
		end
		if (n < 100) tmo("rvalid");
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		axi_wr(a, d, 4'h3, r);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk("rdata", {16'h0, e}, d);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	// Holds a pulse input high for n cycles
	task automatic pulse_err(input int n);
		@(posedge ref_clk);
		prbs_err <= 1'b1;
		repeat (n) @(posedge ref_clk);
		prbs_err <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [15:0] d;
		logic [31:0] rdv;
		logic [1:0] r;
		int n, hi, lo, len, ipg;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		// Reset values
		rd_chk(8'h68, 16'h0000);
		rd_chk(8'h6c, 16'h007d);
		rd_chk(8'h70, 16'h05ee);
		rd_chk(8'h78, 16'h0000);
		// Every squelch code with random other bits; reserved bits must not stick
		for (int i = 0; i < 16; i++) begin
			d = 16'($random(seed));
			d[12:9] = 4'(i);
			ten_mode_pin <= 1'($random(seed));
			wr(8'h68, d);
			repeat (3) @(posedge ref_clk);
			#1;
			chk("lower_thresh_en", {31'h0, d[13]}, {31'h0, lower_thresh_en});
			chk("squelch_code", 32'(i), {28'h0, squelch_code});
			chk("squelch_mv", {22'h0, sq_mv(4'(i))}, {22'h0, squelch_mv});
			chk("nlp_tx_en", {31'h0, ~d[7]}, {31'h0, nlp_tx_en});
			chk("jabber_off", {31'h0, d[0] & ten_mode_pin}, {31'h0, jabber_off});
			rd_chk(8'h68, d & 16'h3e81);
		end
		// Polarity: general status read keeps it, 10BASE-T read clears both
		@(posedge ref_clk);
		pol_inverted_pin <= 1'b1;
		repeat (5) @(posedge ref_clk);
		pol_inverted_pin <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rd_chk(8'h40, 16'h1000);
		rd_chk(8'h40, 16'h1000);
		rd_chk(8'h68, (d & 16'h3e81) | 16'h0010);
		rd_chk(8'h68, d & 16'h3e81);
		rd_chk(8'h40, 16'h0000);
		// Error count latch, then saturation in counter mode zero
		n = 1 + ($unsigned($random(seed)) % 40);
		for (int i = 0; i < n; i++) begin
			pulse_err(1);
			repeat ($unsigned($random(seed)) % 3) @(posedge ref_clk);
		end
		wr(8'h6c, 16'h807d);
		rd_chk(8'h6c, {8'(n), 8'h7d});
		pulse_err(300);
		wr(8'h6c, 16'h807d);
		rd_chk(8'h6c, 16'hff7d);
		// Counter mode one wraps past all ones instead of stopping
		wr(8'h88, 16'h0001);
		n = 256 + ($unsigned($random(seed)) % 40);
		pulse_err(n);
		wr(8'h6c, 16'h807d);
		rd_chk(8'h6c, {8'(n), 8'h7d});
		// Cable diagnostic handshake; read-only bits ignore writes
		wr(8'h78, 16'h4003);
		#1;
		chk("rescal_start", 32'h1, {31'h0, rescal_start});
		rd_chk(8'h78, 16'h4000);
		wr(8'h78, 16'h8000);
		#1;
		chk("diag_start", 32'h1, {31'h0, diag_start});
		chk("rescal_start", 32'h0, {31'h0, rescal_start});
		rd_chk(8'h78, 16'h8000);
		@(posedge ref_clk);
		diag_done_in <= 1'b1;
		diag_fail_in <= 1'b1;
		@(posedge ref_clk);
		diag_done_in <= 1'b0;
		diag_fail_in <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("diag_start", 32'h0, {31'h0, diag_start});
		rd_chk(8'h78, 16'h0003);
		// Interrupt: all four events pending, masked, then the done event alone unmasked and cleared
		rd_chk(8'h80, 16'h000f);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h84, 16'h0001);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h80, 16'h0001);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk(8'h80, 16'h000e);
		// Unmapped addresses answer with an error
		axi_rd(8'hf0, rdv, r);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("rdata", 32'h0, rdv);
		axi_wr(8'hf4, 16'hffff, 4'h3, r);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		// Generator: short random length and gap, two packets measured
		len = 1 + ($unsigned($random(seed)) % 20);
		ipg = 1 + ($unsigned($random(seed)) % 5);
		wr(8'h70, 16'(len));
		wr(8'h6c, 16'(ipg));
		wr(8'h88, 16'h0002);
		n = 0;
		while (bist_byte_valid !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 3000) tmo("bist_byte_valid");
		for (int k = 0; k < 2; k++) begin
			// The first byte of each packet carries the start marker
			chk("bist_pkt_start", 32'h1, {31'h0, bist_pkt_start});
			hi = 0;
			lo = 0;
			while (bist_byte_valid === 1'b1 && hi < 100) begin
				@(posedge ref_clk);
				hi++;
			end
			while (bist_byte_valid !== 1'b1 && lo < 100) begin
				@(posedge ref_clk);
				lo++;
			end
			chk("packet_bytes", 32'(len), 32'(hi));
			chk("gap_bytes", 32'(4 * ipg), 32'(lo));
		end
		wrap_up();
	end
endmodule
